// ---- bench/pnic_core_model.sv ----
`timescale 1ns/1ns
// core side: takes requests after a lag, returns innermost handler on command
module pnic_core_model (
  // core link
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       irq_req,
  input  wire logic [4:0] irq_num,
  output logic            irq_ack,
  output logic            irq_done,
  // bench control
  input  wire logic       accept,
  input  wire logic       ret,
  input  wire logic [3:0] lag,
  output logic      [4:0] last
);
  logic [3:0] wait_q;
  int         depth;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ack  <= 1'b0;
      irq_done <= 1'b0;
      wait_q   <= 4'h0;
      last     <= 5'h0;
      depth = 0;
    end else begin
      irq_ack  <= 1'b0;
      irq_done <= 1'b0;
      wait_q   <= (irq_req && accept && !irq_ack) ? wait_q + 4'h1 : 4'h0;
      // ack only while a request stands, and only once per request
      if (irq_req && accept && !irq_ack && wait_q >= lag) begin
        irq_ack <= 1'b1;
        last    <= irq_num;
        depth++;
      end
      // returns follow nesting, innermost first
      if (ret && depth > 0) begin
        irq_done <= 1'b1;
        depth--;
      end
    end
  end
endmodule

// ---- bench/pnic_top_test.sv ----
`timescale 1ns/1ns
module pnic_top_test;
  logic        REF_CLK, RST_B, HWRITE, HRY, HRESP, IRQ_REQ, CTX_HOLD, ACK, DONE;
  logic        accept, ret;
  logic [1:0]  HTRANS;
  logic [3:0]  lag;
  logic [4:0]  IRQ_NUM, last;
  logic [31:0] HADDR, HWDATA, HRDATA, IRQ_SRC, IRQ_VEC, v, seed;
  int          errors, checks_done, cycles, a, b, w;
  logic [2:0]  pa, pb;
  pnic_top dut_u (.REF_CLK(REF_CLK), .RST_B(RST_B), .HSEL(1'b1), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(pnic_pkg::HSIZE_WORD), .HWDATA(HWDATA),
    .HREADY(HRY), .HRDATA(HRDATA), .HREADYOUT(HRY), .HRESP(HRESP), .IRQ_SRC(IRQ_SRC),
    .IRQ_ACK(ACK), .IRQ_DONE(DONE), .IRQ_REQ(IRQ_REQ), .IRQ_NUM(IRQ_NUM),
    .IRQ_VEC(IRQ_VEC), .CTX_HOLD(CTX_HOLD));
  pnic_core_model core_u (.clk(REF_CLK), .rst_b(RST_B), .irq_req(IRQ_REQ),
    .irq_num(IRQ_NUM), .irq_ack(ACK), .irq_done(DONE), .accept(accept), .ret(ret),
    .lag(lag), .last(last));
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic xfer(input logic [11:0] ad, input logic wrt, input logic [31:0] d);
    HADDR  <= {20'h0, ad};
    HTRANS <= 2'h2;
    HWRITE <= wrt;
    do @(posedge REF_CLK); while (!HRY);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge REF_CLK); while (!HRY);
    v = HRDATA;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(ad, 1'b1, d);
  endtask
  task automatic pri(input int n, input logic [2:0] p);
    // low five bits random: they must not matter
    wr(pnic_pkg::OFS_PRIO_BASE + 12'(4 * n), {24'h0, p, 5'(rnd())});
  endtask
  task automatic settle();
    repeat (6) @(posedge REF_CLK);
  endtask
  task automatic pulse_ret();
    ret <= 1'b1;
    @(posedge REF_CLK);
    ret <= 1'b0;
    settle();
  endtask
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {HADDR, HWDATA, IRQ_SRC, HTRANS, HWRITE, accept, ret, lag, RST_B} = '0;
    seed = 32'h585f;
    repeat (12) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(posedge REF_CLK);
    xfer(pnic_pkg::OFS_GROUP, 1'b0, 0); cmp("group", 32'h3, v);
    cmp("resp", 0, HRESP);
    xfer(12'h0f0, 1'b0, 0); cmp("unmapped", 32'h0, v);
    wr(pnic_pkg::OFS_VBASE, 32'h4000);
    wr(pnic_pkg::OFS_ENABLE, 32'hffff_ffff);
    wr(pnic_pkg::OFS_PEND_SET, 32'h80);
    settle(); cmp("gate closed", 0, IRQ_REQ);
    wr(pnic_pkg::OFS_GATE, 32'h1);
    settle(); cmp("gate open", 32'h7, {IRQ_REQ, IRQ_NUM} & 32'h3f ^ 32'h20);
    wr(pnic_pkg::OFS_ENABLE, 32'h0);
    settle(); cmp("disabled", 0, IRQ_REQ);
    xfer(pnic_pkg::OFS_PEND_SET, 1'b0, 0); cmp("pend kept", 32'h80, v);
    wr(pnic_pkg::OFS_ENABLE, 32'hffff_ffff);
    wr(pnic_pkg::OFS_PEND_CLR, 32'h80);
    settle(); cmp("discarded", 0, IRQ_REQ);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 9 : rnd() % 32;
      b = (i == 0) ? 5 : (a + 1 + rnd() % 31) % 32;
      pa = (i == 0) ? 3'h4 : 3'(rnd());
      pb = (i == 0) ? 3'h4 : 3'(rnd());
      pri(a, pa);
      pri(b, pb);
      // random low bits written above must read back as zero
      xfer(pnic_pkg::OFS_PRIO_BASE + 12'(4 * a), 1'b0, 0);
      cmp("prio bits", {24'h0, pa, 5'h0}, v);
      w = (pa < pb || (pa == pb && a < b)) ? a : b;
      wr(pnic_pkg::OFS_PEND_SET, (32'h1 << a) | (32'h1 << b));
      settle(); cmp("winner", w, IRQ_NUM);
      cmp("vector", 32'h4000 + 4 * w, IRQ_VEC);
      wr(pnic_pkg::OFS_PEND_CLR, 32'hffff_ffff);
    end
    pri(3, 3'h2);
    wr(pnic_pkg::OFS_MASK, 32'h40);
    wr(pnic_pkg::OFS_PEND_SET, 32'h8);
    settle(); cmp("masked", 0, IRQ_REQ);
    wr(pnic_pkg::OFS_MASK, 32'h60);
    settle(); cmp("unmasked", 1, IRQ_REQ);
    wr(pnic_pkg::OFS_MASK, 32'h0);
    wr(pnic_pkg::OFS_PEND_CLR, 32'h8);
    pri(10, 3'h4);
    pri(2, 3'h2);
    for (int g = 0; g < 3; g++) begin
      // g 0: group 3, g 1: group 7 with a held line, g 2: group 0
      wr(pnic_pkg::OFS_GROUP, (g == 2) ? 0 : 3 + 4 * g);
      accept <= 1'b1;
      lag <= rnd() % 8;
      if (g == 1) IRQ_SRC <= 32'h400;
      else wr(pnic_pkg::OFS_PEND_SET, 32'h400);
      settle();
      repeat (8) @(posedge REF_CLK);
      IRQ_SRC <= 32'h0;
      // handler cleared its cause; drop the copy latched while the line was still high
      wr(pnic_pkg::OFS_PEND_CLR, 32'h400);
      cmp("first taken", 10, last);
      cmp("hold", 1, CTX_HOLD);
      wr(pnic_pkg::OFS_PEND_SET, 32'h4);
      settle();
      repeat (8) @(posedge REF_CLK);
      cmp("preempt", (g == 2) ? 10 : 2, last);
      pulse_ret();
      repeat (8) @(posedge REF_CLK);
      cmp("chain", 2, last);
      cmp("nested hold", 1, CTX_HOLD);
      pulse_ret();
      cmp("drained", 0, CTX_HOLD);
    end
    conclude();
  end
endmodule

// ---- hw/pnic_arb.sv ----
`timescale 1ns/1ns
// picks the smallest key; on equal keys the lowest index wins
module pnic_arb #(
  parameter int N  = 32,
  parameter int KW = 3,
  parameter int IW = 5
) (
  // candidates
  input  wire logic [N-1:0]    valid,
  input  wire logic [N*KW-1:0] keys,
  // winner
  output logic                 found,
  output logic [IW-1:0]        idx,
  output logic [KW-1:0]        key
);
  always_comb begin
    found = 1'b0;
    idx   = '0;
    key   = '0;
    // walking downward with <= lets the lower index take ties
    for (int i = N - 1; i >= 0; i--) begin
      if (valid[i] && (!found || keys[i*KW +: KW] <= key)) begin
        found = 1'b1;
        idx   = IW'(i);
        key   = keys[i*KW +: KW];
      end
    end
  end
endmodule

// ---- hw/pnic_pkg.sv ----
package pnic_pkg;
  // geometry
  localparam int NSRC  = 32;
  localparam int IDXW  = 5;
  localparam int PRIW  = 3;
  localparam int AW    = 12;

  // register byte offsets
  localparam logic [AW-1:0] OFS_ENABLE    = 12'h000;
  localparam logic [AW-1:0] OFS_PEND_SET  = 12'h004;
  localparam logic [AW-1:0] OFS_PEND_CLR  = 12'h008;
  localparam logic [AW-1:0] OFS_ACTIVE    = 12'h00c;
  localparam logic [AW-1:0] OFS_GATE      = 12'h010;
  localparam logic [AW-1:0] OFS_GROUP     = 12'h014;
  localparam logic [AW-1:0] OFS_MASK      = 12'h018;
  localparam logic [AW-1:0] OFS_VBASE     = 12'h01c;
  localparam logic [AW-1:0] OFS_STATUS    = 12'h020;
  localparam logic [AW-1:0] OFS_PRIO_BASE = 12'h100;

  // field positions
  localparam int GATE_BIT      = 0;
  localparam int GROUP_LSB     = 0;
  localparam int PRIO_LSB      = 5;
  localparam int STAT_NUM_LSB  = 0;
  localparam int STAT_REQ_BIT  = 8;
  localparam int STAT_HOLD_BIT = 9;
  localparam int STAT_RUNV_BIT = 15;
  localparam int STAT_RUN_LSB  = 12;

  // reset values
  localparam logic [NSRC-1:0] RST_ENABLE = 32'h0000_0000;
  localparam logic            RST_GATE   = 1'b0;
  localparam logic [2:0]      RST_GROUP  = 3'h3;
  localparam logic [PRIW-1:0] RST_MASK   = 3'h0;
  localparam logic [31:0]     RST_VBASE  = 32'h0000_0000;
  localparam logic [PRIW-1:0] RST_PRIO   = 3'h0;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WR   = 3'b010,
    BUS_RD   = 3'b100
  } pnic_bus_t;
endpackage

// ---- hw/pnic_top.sv ----
`timescale 1ns/1ns
module pnic_top (
  // clock and reset
  input  wire logic                      REF_CLK,
  input  wire logic                      RST_B,
  // ahb-lite slave
  input  wire logic                      HSEL,
  input  wire logic [31:0]               HADDR,
  input  wire logic [1:0]                HTRANS,
  input  wire logic                      HWRITE,
  input  wire logic [2:0]                HSIZE,
  input  wire logic [31:0]               HWDATA,
  input  wire logic                      HREADY,
  output logic      [31:0]               HRDATA,
  output logic                           HREADYOUT,
  output logic                           HRESP,
  // interrupt sources
  input  wire logic [pnic_pkg::NSRC-1:0] IRQ_SRC,
  // core side
  input  wire logic                      IRQ_ACK,
  input  wire logic                      IRQ_DONE,
  output logic                           IRQ_REQ,
  output logic      [pnic_pkg::IDXW-1:0] IRQ_NUM,
  output logic      [31:0]               IRQ_VEC,
  output logic                           CTX_HOLD
);
  localparam int N  = pnic_pkg::NSRC;
  localparam int KW = pnic_pkg::PRIW;
  localparam int IW = pnic_pkg::IDXW;

  // bus state
  pnic_pkg::pnic_bus_t bus_q, bus_d;
  logic [pnic_pkg::AW-1:0] addr_q, addr_d;
  logic                    ready_q, ready_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    wsize_q, wsize_d;
  // configuration
  logic [N-1:0]  en_q, en_d;
  logic          gate_q, gate_d;
  logic [2:0]    grp_q, grp_d;
  logic [KW-1:0] mask_q, mask_d;
  logic [31:0]   vbase_q, vbase_d;
  logic [KW-1:0] prio_q [N];
  logic [KW-1:0] prio_d [N];
  // interrupt state
  logic [N-1:0]  pend_q, pend_d;
  logic [N-1:0]  act_q, act_d;
  logic          req_q, req_d;
  logic [IW-1:0] num_q, num_d;
  logic [31:0]   vec_q, vec_d;
  logic          hold_q, hold_d;

  logic [N*KW-1:0] prio_flat, pre_flat;
  logic            p_found, a_found;
  logic [IW-1:0]   p_idx, a_idx;
  logic [KW-1:0]   p_key, a_key, win_pre;
  logic            accept, wr_en, take, done, mask_ok, preempt_ok;
  logic [N-1:0]    sw_set, sw_clr;
  logic [31:0]     rd_val;

  // preemption part of a priority under the current split
  function automatic logic [KW-1:0] pre_of(input logic [KW-1:0] p, input logic [2:0] g);
    logic [KW-1:0] m;
    case (g)
      3'h0:    m = 3'b000;
      3'h1:    m = 3'b100;
      3'h2:    m = 3'b110;
      default: m = 3'b111;
    endcase
    return p & m;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_key
      assign prio_flat[gi*KW +: KW] = prio_q[gi];
      assign pre_flat[gi*KW +: KW]  = pre_of(prio_q[gi], grp_q);
    end
  endgenerate

  // best pending enabled source, full priority then index
  pnic_arb #(.N(N), .KW(KW), .IW(IW)) u_pend_arb (
    .valid (pend_q & en_q),
    .keys  (prio_flat),
    .found (p_found),
    .idx   (p_idx),
    .key   (p_key)
  );

  // innermost running handler has the best preemption level
  pnic_arb #(.N(N), .KW(KW), .IW(IW)) u_act_arb (
    .valid (act_q),
    .keys  (pre_flat),
    .found (a_found),
    .idx   (a_idx),
    .key   (a_key)
  );

  // ---------------- bus ----------------
  assign accept = ready_q && HSEL && HTRANS[1] && HREADY;
  assign wr_en  = (bus_q == pnic_pkg::BUS_WR) && wsize_q;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (addr_q)
      pnic_pkg::OFS_ENABLE:   rd_val = en_q;
      pnic_pkg::OFS_PEND_SET: rd_val = pend_q;
      pnic_pkg::OFS_PEND_CLR: rd_val = pend_q;
      pnic_pkg::OFS_ACTIVE:   rd_val = act_q;
      pnic_pkg::OFS_GATE:     rd_val[pnic_pkg::GATE_BIT] = gate_q;
      pnic_pkg::OFS_GROUP:    rd_val[pnic_pkg::GROUP_LSB +: 3] = grp_q;
      pnic_pkg::OFS_MASK:     rd_val[pnic_pkg::PRIO_LSB +: KW] = mask_q;
      pnic_pkg::OFS_VBASE:    rd_val = vbase_q;
      pnic_pkg::OFS_STATUS: begin
        rd_val[pnic_pkg::STAT_NUM_LSB +: IW]  = num_q;
        rd_val[pnic_pkg::STAT_REQ_BIT]        = req_q;
        rd_val[pnic_pkg::STAT_HOLD_BIT]       = hold_q;
        rd_val[pnic_pkg::STAT_RUN_LSB +: KW]  = a_key;
        rd_val[pnic_pkg::STAT_RUNV_BIT]       = a_found;
      end
      default: begin
        if (addr_q[11:7] == pnic_pkg::OFS_PRIO_BASE[11:7]) begin
          rd_val[pnic_pkg::PRIO_LSB +: KW] = prio_q[addr_q[6:2]];
        end
      end
    endcase
  end

  // reads take one wait state so a write just before is visible
  always_comb begin
    bus_d   = pnic_pkg::BUS_IDLE;
    addr_d  = addr_q;
    ready_d = 1'b1;
    rdata_d = rdata_q;
    wsize_d = wsize_q;
    if (accept) begin
      addr_d  = {HADDR[pnic_pkg::AW-1:2], 2'b00};
      wsize_d = (HSIZE == pnic_pkg::HSIZE_WORD);
      bus_d   = HWRITE ? pnic_pkg::BUS_WR : pnic_pkg::BUS_RD;
      ready_d = HWRITE;
    end else if (bus_q == pnic_pkg::BUS_RD) begin
      rdata_d = rd_val;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      bus_q   <= pnic_pkg::BUS_IDLE;
      addr_q  <= '0;
      ready_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      wsize_q <= 1'b0;
    end else begin
      bus_q   <= bus_d;
      addr_q  <= addr_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      wsize_q <= wsize_d;
    end
  end

  // ---------------- configuration ----------------
  assign sw_set = (wr_en && addr_q == pnic_pkg::OFS_PEND_SET) ? HWDATA : '0;
  assign sw_clr = (wr_en && addr_q == pnic_pkg::OFS_PEND_CLR) ? HWDATA : '0;

  always_comb begin
    en_d    = en_q;
    gate_d  = gate_q;
    grp_d   = grp_q;
    mask_d  = mask_q;
    vbase_d = vbase_q;
    prio_d  = prio_q;
    if (wr_en) begin
      case (addr_q)
        pnic_pkg::OFS_ENABLE: en_d   = HWDATA;
        pnic_pkg::OFS_GATE:   gate_d = HWDATA[pnic_pkg::GATE_BIT];
        pnic_pkg::OFS_GROUP:  grp_d  = HWDATA[pnic_pkg::GROUP_LSB +: 3];
        pnic_pkg::OFS_MASK:   mask_d = HWDATA[pnic_pkg::PRIO_LSB +: KW];
        pnic_pkg::OFS_VBASE:  vbase_d = {HWDATA[31:2], 2'b00};
        default: begin
          if (addr_q[11:7] == pnic_pkg::OFS_PRIO_BASE[11:7]) begin
            prio_d[addr_q[6:2]] = HWDATA[pnic_pkg::PRIO_LSB +: KW];
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      en_q    <= pnic_pkg::RST_ENABLE;
      gate_q  <= pnic_pkg::RST_GATE;
      grp_q   <= pnic_pkg::RST_GROUP;
      mask_q  <= pnic_pkg::RST_MASK;
      vbase_q <= pnic_pkg::RST_VBASE;
      for (int i = 0; i < N; i++) begin
        prio_q[i] <= pnic_pkg::RST_PRIO;
      end
    end else begin
      en_q    <= en_d;
      gate_q  <= gate_d;
      grp_q   <= grp_d;
      mask_q  <= mask_d;
      vbase_q <= vbase_d;
      prio_q  <= prio_d;
    end
  end

  // ---------------- interrupt state ----------------
  assign take       = IRQ_ACK && req_q;
  assign done       = IRQ_DONE && a_found;
  assign win_pre    = pre_of(p_key, grp_q);
  assign mask_ok    = (mask_q == '0) || (p_key < mask_q);
  assign preempt_ok = !a_found || (win_pre < a_key);

  always_comb begin
    // hardware and software sets win over a software clear
    pend_d = (pend_q & ~sw_clr) | (IRQ_SRC & en_q) | sw_set;
    act_d  = act_q;
    if (done) begin
      act_d[a_idx] = 1'b0;
    end
    if (take) begin
      pend_d[num_q] = 1'b0;
      act_d[num_q]  = 1'b1;
    end
    // hold off one cycle after an accept so the new state settles
    req_d  = gate_q && p_found && mask_ok && preempt_ok && !take;
    num_d  = req_d ? p_idx : num_q;
    vec_d  = req_d ? vbase_q + 32'({p_idx, 2'b00}) : vec_q;
    hold_d = (|act_q) || (|(pend_q & en_q));
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_q <= '0;
      act_q  <= '0;
      req_q  <= 1'b0;
      num_q  <= '0;
      vec_q  <= 32'h0000_0000;
      hold_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
      act_q  <= act_d;
      req_q  <= req_d;
      num_q  <= num_d;
      vec_q  <= vec_d;
      hold_q <= hold_d;
    end
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = ready_q;
  assign HRESP     = 1'b0;
  assign IRQ_REQ   = req_q;
  assign IRQ_NUM   = num_q;
  assign IRQ_VEC   = vec_q;
  assign CTX_HOLD  = hold_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  logic [N-1:0] beats;
  generate
    for (gi = 0; gi < N; gi++) begin : g_tie
      assign beats[gi] = pend_q[gi] && en_q[gi] && (prio_q[gi] <= p_key) && (gi < p_idx);
    end
  endgenerate

  sequence s_rd_accept;
    accept && !HWRITE;
  endsequence
  sequence s_rd_answer;
    !HREADYOUT ##1 HREADYOUT;
  endsequence

  chk_read_wait: assert property (s_rd_accept |=> s_rd_answer)
    else $error("read did not answer after one wait state");
  chk_gate_blocks: assert property (!gate_q |=> !IRQ_REQ)
    else $error("request raised with global gate closed");
  chk_vec_addr: assert property (IRQ_REQ |-> IRQ_VEC == vbase_q + 32'({IRQ_NUM, 2'b00}))
    else $error("handler address does not match source");
  chk_mask_level: assert property (req_d && mask_q != '0 |-> p_key < mask_q)
    else $error("masked priority reached the core");
  chk_no_same_grp: assert property (req_d && a_found |-> win_pre < a_key)
    else $error("request without strictly better preemption group");
  chk_tie_low_index: assert property (p_found |-> beats == '0)
    else $error("winner is not the lowest index of its priority");
  chk_ack_entry: assert property (take |=> act_q[$past(num_q)] && !IRQ_REQ)
    else $error("accepted source not marked running");
  chk_pend_hold: assert property (pend_q != '0 && !take && sw_clr == '0 |=> (pend_q & $past(pend_q)) == $past(pend_q))
    else $error("pending bit lost without entry or clear");
  chk_ctx_hold: assert property ((|act_q) |=> CTX_HOLD [*1] ##0 (|$past(act_q)))
    else $error("context released while handlers still run");
endmodule
